// ---- sdsup_pkg.sv ----
package sdsup_pkg;
    localparam int unsigned CLK_NS         = 10;
    // monitored oscillator arrives divided down so the pin filter sees every edge
    localparam int unsigned OSC_DIV        = 8;
    localparam int unsigned OSC_WIN_NS     = 1000 * OSC_DIV;
    localparam int unsigned OSC_WIN_CYC    = OSC_WIN_NS / CLK_NS;
    localparam int unsigned OSC_MIN_MHZ    = 35;
    localparam int unsigned OSC_MAX_MHZ    = 45;
    localparam int unsigned OSC_MIN_EDGES  = OSC_MIN_MHZ;
    localparam int unsigned OSC_MAX_EDGES  = OSC_MAX_MHZ;
    localparam int unsigned WDT_TIMEOUT_MS = 500;
    localparam int unsigned WDT_CYC        = WDT_TIMEOUT_MS * 1000000 / CLK_NS;
    localparam logic [2:0]  CRC_BANK_FIRST = 3'h1;
    localparam logic [2:0]  CRC_BANK_LAST  = 3'h5;
    localparam logic [7:0]  CRC_BYTE_IDX   = 8'h08;
    localparam logic [7:0]  CRC_POLY       = 8'h07;
    localparam logic [7:0]  CRC_INIT       = 8'hFF;
    localparam logic [7:0]  BIST_PAT0      = 8'h55;
    localparam logic [7:0]  BIST_PAT1      = 8'hAA;
    localparam logic [7:0]  REG_CTRL       = 8'h00;
    localparam logic [7:0]  REG_LOWPWR     = 8'h04;
    localparam logic [7:0]  REG_STATUS     = 8'h08;
    localparam logic [7:0]  REG_CACHE      = 8'h0C;
    localparam logic [7:0]  REG_RAM        = 8'h10;
    localparam int unsigned CTRL_CLKMON    = 0;
    localparam int unsigned CTRL_WDT       = 1;
    localparam int unsigned CTRL_BIST      = 2;
    localparam int unsigned CTRL_SVC       = 3;
    localparam int unsigned CACHE_BANK_LSB = 8;
    localparam int unsigned CACHE_LAST     = 16;
    localparam int unsigned RAM_DATA_LSB   = 8;
    localparam int unsigned RAM_WE         = 16;
    localparam logic        CLKMON_RESET   = 1'b1;
    localparam logic        WDT_EN_RESET   = 1'b0;
    localparam logic [4:0]  LOWPWR_RESET   = 5'h1F;
    typedef enum logic [2:0] {
        SDSUP_B_IDLE  = 3'h0,
        SDSUP_B_FILL  = 3'h1,
        SDSUP_B_CHK0  = 3'h2,
        SDSUP_B_CHK1  = 3'h3,
        SDSUP_B_DONE  = 3'h4
    } sdsup_bist_t;
endpackage

// ---- sdsup_if.sv ----
`timescale 1ns/1ps
`default_nettype none
interface sdsup_if;
    logic       clkmon_en;
    logic       wdt_en;
    logic       wdt_service;
    logic       bist_start;
    logic [4:0] lowpwr_en;
    logic       cache_valid;
    logic [2:0] cache_bank;
    logic [7:0] cache_byte;
    logic       cache_last;
    logic       ram_we;
    logic [7:0] ram_addr;
    logic [7:0] ram_wdata;
    logic [7:0] ram_rdata;
    logic       crc_err;
    logic       trim_err;
    logic       bist_done;
    logic       bist_fail;
    logic       bist_busy;
    logic       core_rst;
    logic       chip_rst;
    modport dev (
        input  clkmon_en, wdt_en, wdt_service, bist_start, lowpwr_en,
        input  cache_valid, cache_bank, cache_byte, cache_last,
        input  ram_we, ram_addr, ram_wdata,
        output ram_rdata, crc_err, trim_err, bist_done, bist_fail, bist_busy, core_rst, chip_rst
    );
    modport host (
        output clkmon_en, wdt_en, wdt_service, bist_start, lowpwr_en,
        output cache_valid, cache_bank, cache_byte, cache_last,
        output ram_we, ram_addr, ram_wdata,
        input  ram_rdata, crc_err, trim_err, bist_done, bist_fail, bist_busy, core_rst, chip_rst
    );
endinterface
`default_nettype wire

// ---- sdsup_sync.sv ----
`timescale 1ns/1ps
`default_nettype none
module sdsup_sync
    import sdsup_pkg::*;
(
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic pin_i,
    output logic      level_o
);
    typedef struct packed {
        logic [2:0] stage;
        logic       level;
    } sdsup_sync_t;

    sdsup_sync_t sync_reg;
    sdsup_sync_t sync_next;

    always_comb begin
        sync_next       = sync_reg;
        sync_next.stage = {sync_reg.stage[1:0], pin_i};
        // the first stage feeds only the second; the level moves once stages two and three agree
        if (sync_reg.stage[1] == sync_reg.stage[2]) begin
            sync_next.level = sync_reg.stage[2];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sync_reg <= '0;
        end else begin
            sync_reg <= sync_next;
        end
    end

    assign level_o = sync_reg.level;
endmodule
`default_nettype wire

// ---- sdsup_host.sv ----
`timescale 1ns/1ps
`default_nettype none
module sdsup_host
    import sdsup_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    sdsup_if.host            link
);
    typedef struct packed {
        logic        ack;
        logic [31:0] rdat;
        logic        clkmon_en;
        logic        wdt_en;
        logic        svc;
        logic        bist_start;
        logic [4:0]  lowpwr;
        logic        cache_valid;
        logic [2:0]  cache_bank;
        logic [7:0]  cache_byte;
        logic        cache_last;
        logic        ram_we;
        logic [7:0]  ram_addr;
        logic [7:0]  ram_wdata;
    } sdsup_host_t;

    sdsup_host_t h_reg;
    sdsup_host_t h_next;
    logic        req;
    logic [31:0] wmask;
    logic [31:0] wd;

    assign req   = wb_cyc_i & wb_stb_i & ~h_reg.ack;
    assign wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    assign wd    = wb_dat_i & wmask;

    always_comb begin
        h_next             = h_reg;
        h_next.ack         = req;
        h_next.bist_start  = 1'b0;
        h_next.cache_valid = 1'b0;
        h_next.ram_we      = 1'b0;
        if (req && !wb_we_i) begin
            unique case (wb_adr_i)
                // service line is write-only: software cannot see its level
                REG_CTRL:   h_next.rdat = {30'h0, h_reg.wdt_en, h_reg.clkmon_en};
                REG_LOWPWR: h_next.rdat = {27'h0, h_reg.lowpwr};
                REG_STATUS: h_next.rdat = {25'h0, link.chip_rst, link.core_rst, link.bist_busy,
                                           link.bist_fail, link.bist_done, link.trim_err, link.crc_err};
                // RAM reads as zero while the self-test owns it
                REG_RAM:    h_next.rdat = link.bist_busy ? 32'h0 : {24'h0, link.ram_rdata};
                default:    h_next.rdat = 32'h0;
            endcase
        end
        if (req && wb_we_i) begin
            unique case (wb_adr_i)
                REG_CTRL: begin
                    if (wb_sel_i[0]) begin
                        h_next.clkmon_en = wd[CTRL_CLKMON];
                        h_next.wdt_en    = wd[CTRL_WDT];
                    end
                    h_next.bist_start = wd[CTRL_BIST];
                    h_next.svc        = h_reg.svc ^ wd[CTRL_SVC];
                end
                REG_LOWPWR: begin
                    if (wb_sel_i[0]) begin
                        h_next.lowpwr = wd[4:0];
                    end
                end
                REG_CACHE: begin
                    // banks pass in whatever order software writes them, bank zero included
                    h_next.cache_valid = 1'b1;
                    h_next.cache_byte  = wd[7:0];
                    h_next.cache_bank  = wd[CACHE_BANK_LSB +: 3];
                    h_next.cache_last  = wd[CACHE_LAST];
                end
                REG_RAM: begin
                    h_next.ram_addr  = wd[7:0];
                    h_next.ram_wdata = wd[RAM_DATA_LSB +: 8];
                    h_next.ram_we    = wd[RAM_WE] & ~link.bist_busy;
                end
                default: begin
                end
            endcase
        end
        // a whole-chip reset restores every setting; a core watchdog reset leaves them alone
        if (link.chip_rst) begin
            h_next.clkmon_en = CLKMON_RESET;
            h_next.wdt_en    = WDT_EN_RESET;
            h_next.lowpwr    = LOWPWR_RESET;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            h_reg           <= '0;
            h_reg.clkmon_en <= CLKMON_RESET;
            h_reg.wdt_en    <= WDT_EN_RESET;
            h_reg.lowpwr    <= LOWPWR_RESET;
        end else begin
            h_reg <= h_next;
        end
    end

    assign wb_ack_o         = h_reg.ack;
    assign wb_dat_o         = h_reg.rdat;
    assign link.clkmon_en   = h_reg.clkmon_en;
    assign link.wdt_en      = h_reg.wdt_en;
    assign link.wdt_service = h_reg.svc;
    assign link.bist_start  = h_reg.bist_start;
    assign link.lowpwr_en   = h_reg.lowpwr;
    assign link.cache_valid = h_reg.cache_valid;
    assign link.cache_bank  = h_reg.cache_bank;
    assign link.cache_byte  = h_reg.cache_byte;
    assign link.cache_last  = h_reg.cache_last;
    assign link.ram_we      = h_reg.ram_we;
    assign link.ram_addr    = h_reg.ram_addr;
    assign link.ram_wdata   = h_reg.ram_wdata;
endmodule
`default_nettype wire

// ---- sdsup_device.sv ----
// Function
// - crc sits in ninth byte of bank five
// - software loads banks one to five ascending
// - bank five load computes crc, updates status
// - trim checked before core reset release
// - bank zero excluded from hardware crc
// - writing one starts ram self-test
// - done flag set when test completes
// - fail bit reports ram fault after done
// - self-test runs once per power cycle
// - core keeps off ram during self-test
// - watchdog monitors main clock from either source
// - clock outside 35-45MHz resets whole chip
// - clearing enable disables clock watchdog reset
// - unserviced 500ms watchdog resets the core
// - service by toggling line, no readback
// - clearing enable stops core watchdog resets
// - watchdog reset clears both dac outputs
// - watchdog reset keeps other settings unchanged
// - five separate low-power enable controls
// - core and memories never slowed or stopped
`timescale 1ns/1ps
`default_nettype none
module sdsup_device
    import sdsup_pkg::*;
#(
    parameter int unsigned RAM_DEPTH   = 256,
    parameter int unsigned WDT_CYCLES  = WDT_CYC,
    parameter int unsigned WIN_CYCLES  = OSC_WIN_CYC
)(
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic       osc_div_i,
    input  wire logic [8:0] trim_word_i,
    output logic            bridge_supply_enable_o,
    output logic            second_dac_enable_o,
    output logic            front_end_enable_o,
    output logic            digital_interface_clock_enable_o,
    output logic            eeprom_clock_enable_o,
    output logic            dac_clear_o,
    sdsup_if.dev            link
);
    localparam int unsigned AW = $clog2(RAM_DEPTH);

    if (RAM_DEPTH < 2 || RAM_DEPTH > 256 || (1 << AW) != RAM_DEPTH) begin
        $error("RAM_DEPTH must be a power of two from 2 to 256");
    end
    if (WDT_CYCLES < 2 || WIN_CYCLES < 2 || WIN_CYCLES > 1023) begin
        $error("watchdog or window count out of range");
    end

    typedef struct packed {
        logic [RAM_DEPTH-1:0][7:0] mem;
        logic [7:0]                rdata;
        sdsup_bist_t               bst;
        logic [AW-1:0]             baddr;
        logic                      bused;
        logic                      bdone;
        logic                      bfail;
        logic                      trim_done;
        logic                      trim_err;
        logic [7:0]                crc;
        logic [7:0]                crc_ref;
        logic [2:0]                exp_bank;
        logic [7:0]                idx;
        logic                      seq_ok;
        logic                      crc_err;
        logic                      svc_prev;
        logic [31:0]               wcnt;
        logic                      wfire;
        logic                      osc_prev;
        logic [9:0]                wincnt;
        logic [6:0]                ecnt;
        logic                      chip_rst;
        logic [4:0]                lp;
    } sdsup_dev_t;

    sdsup_dev_t d_reg;
    sdsup_dev_t d_next;
    logic       osc_level;
    logic       last_addr;
    logic [7:0] crc_base;
    logic       in_crc;

    function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] b);
        logic [7:0] x;
        x = c ^ b;
        for (int i = 0; i < 8; i++) begin
            x = x[7] ? ((x << 1) ^ CRC_POLY) : (x << 1);
        end
        return x;
    endfunction

    // the monitored clock comes in from the oscillator domain
    sdsup_sync sdsup_sync_inst (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .pin_i   (osc_div_i),
        .level_o (osc_level)
    );

    assign last_addr = (d_reg.baddr == AW'(RAM_DEPTH - 1));
    assign in_crc    = (link.cache_bank >= CRC_BANK_FIRST) && (link.cache_bank <= CRC_BANK_LAST);
    assign crc_base  = (d_reg.idx == 8'h00 && link.cache_bank == CRC_BANK_FIRST) ? CRC_INIT : d_reg.crc;

    always_comb begin
        d_next       = d_reg;
        d_next.wfire = 1'b0;
        d_next.chip_rst = 1'b0;
        d_next.lp    = link.lowpwr_en;

        // trim parity is odd when valid; result is latched before the core leaves reset
        if (!d_reg.trim_done) begin
            d_next.trim_done = 1'b1;
            d_next.trim_err  = ~^trim_word_i;
        end

        // eeprom cache stream: the crc byte is stored, every other byte of banks 1..5 is folded in
        if (link.cache_valid && in_crc) begin
            if (d_reg.idx == 8'h00 && link.cache_bank == CRC_BANK_FIRST) begin
                d_next.seq_ok = 1'b1;
            end else if (d_reg.idx == 8'h00 && link.cache_bank != d_reg.exp_bank) begin
                d_next.seq_ok = 1'b0;
            end
            if (link.cache_bank == CRC_BANK_LAST && d_reg.idx == CRC_BYTE_IDX) begin
                d_next.crc_ref = link.cache_byte;
                d_next.crc     = crc_base;
            end else begin
                d_next.crc = crc8(crc_base, link.cache_byte);
            end
            d_next.idx = d_reg.idx + 8'h01;
            if (link.cache_last) begin
                d_next.idx      = 8'h00;
                d_next.exp_bank = link.cache_bank + 3'h1;
                if (link.cache_bank == CRC_BANK_LAST) begin
                    d_next.crc_err = ~d_next.seq_ok | (d_next.crc != d_next.crc_ref);
                end
            end
        end

        // core side ram port, refused while the self-test owns the array
        d_next.rdata = d_reg.mem[link.ram_addr[AW-1:0]];
        if (link.ram_we && d_reg.bst == SDSUP_B_IDLE || link.ram_we && d_reg.bst == SDSUP_B_DONE) begin
            d_next.mem[link.ram_addr[AW-1:0]] = link.ram_wdata;
        end

        // three-pass, two-pattern test; the used flag survives every reset but power-up
        unique case (d_reg.bst)
            SDSUP_B_IDLE: begin
                if (link.bist_start && !d_reg.bused) begin
                    d_next.bst   = SDSUP_B_FILL;
                    d_next.bused = 1'b1;
                    d_next.baddr = '0;
                end
            end
            SDSUP_B_FILL: begin
                d_next.mem[d_reg.baddr] = BIST_PAT0;
                d_next.baddr = d_reg.baddr + AW'(1);
                if (last_addr) begin
                    d_next.bst = SDSUP_B_CHK0;
                end
            end
            SDSUP_B_CHK0: begin
                if (d_reg.mem[d_reg.baddr] != BIST_PAT0) begin
                    d_next.bfail = 1'b1;
                end
                d_next.mem[d_reg.baddr] = BIST_PAT1;
                d_next.baddr = d_reg.baddr + AW'(1);
                if (last_addr) begin
                    d_next.bst = SDSUP_B_CHK1;
                end
            end
            SDSUP_B_CHK1: begin
                if (d_reg.mem[d_reg.baddr] != BIST_PAT1) begin
                    d_next.bfail = 1'b1;
                end
                d_next.baddr = d_reg.baddr + AW'(1);
                if (last_addr) begin
                    d_next.bst   = SDSUP_B_DONE;
                    d_next.bdone = 1'b1;
                end
            end
            SDSUP_B_DONE: begin
            end
            default: begin
                d_next.bst = SDSUP_B_IDLE;
            end
        endcase

        // software watchdog: held while the core is in reset or the enable is clear
        d_next.svc_prev = link.wdt_service;
        if (!link.wdt_en || !d_reg.trim_done || d_reg.wfire) begin
            d_next.wcnt = 32'h0;
        end else if (link.wdt_service != d_reg.svc_prev) begin
            d_next.wcnt = 32'h0;
        end else if (d_reg.wcnt == WDT_CYCLES - 1) begin
            d_next.wfire = 1'b1;
            d_next.wcnt  = 32'h0;
        end else begin
            d_next.wcnt = d_reg.wcnt + 32'h1;
        end

        // frequency window: count divided-clock rising edges over a fixed span
        d_next.osc_prev = osc_level;
        if (osc_level && !d_reg.osc_prev && d_reg.ecnt != 7'h7F) begin
            d_next.ecnt = d_reg.ecnt + 7'h01;
        end
        if (d_reg.wincnt == 10'(WIN_CYCLES - 1)) begin
            d_next.wincnt = 10'h0;
            d_next.ecnt   = 7'h0;
            if (link.clkmon_en && (d_reg.ecnt < 7'(OSC_MIN_EDGES) || d_reg.ecnt > 7'(OSC_MAX_EDGES))) begin
                d_next.chip_rst = 1'b1;
            end
        end else begin
            d_next.wincnt = d_reg.wincnt + 10'h1;
        end

        // a chip reset reruns the trim check but keeps ram contents and the one-shot used flag
        if (d_reg.chip_rst) begin
            d_next           = '0;
            d_next.mem       = d_reg.mem;
            d_next.bused     = d_reg.bused;
            d_next.lp        = link.lowpwr_en;
            d_next.svc_prev  = link.wdt_service;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            d_reg <= '0;
        end else begin
            d_reg <= d_next;
        end
    end

    // the enables only reach peripheral blocks; no core or memory clock is gated here
    assign bridge_supply_enable_o           = d_reg.lp[0];
    assign second_dac_enable_o              = d_reg.lp[1];
    assign front_end_enable_o               = d_reg.lp[2];
    assign digital_interface_clock_enable_o = d_reg.lp[3];
    assign eeprom_clock_enable_o            = d_reg.lp[4];
    // only the dac data is cleared; other settings stay in the host registers
    assign dac_clear_o    = d_reg.wfire;
    assign link.core_rst  = ~d_reg.trim_done | d_reg.wfire;
    assign link.chip_rst  = d_reg.chip_rst;
    assign link.ram_rdata = d_reg.rdata;
    assign link.crc_err   = d_reg.crc_err;
    assign link.trim_err  = d_reg.trim_err;
    assign link.bist_done = d_reg.bdone;
    assign link.bist_fail = d_reg.bfail & d_reg.bdone;
    assign link.bist_busy = (d_reg.bst != SDSUP_B_IDLE) && (d_reg.bst != SDSUP_B_DONE);
endmodule
`default_nettype wire

// ---- sdsup_chk.sv ----
`timescale 1ns/1ps
`default_nettype none
module sdsup_chk #(
    parameter int unsigned WDT_CYCLES = 200
)(
    input wire logic       clk_i,
    input wire logic       rst_i,
    input wire logic       clkmon_en,
    input wire logic       wdt_en,
    input wire logic       wdt_service,
    input wire logic       bist_start,
    input wire logic       cache_valid,
    input wire logic [2:0] cache_bank,
    input wire logic       cache_last,
    input wire logic       crc_err,
    input wire logic       bist_done,
    input wire logic       bist_fail,
    input wire logic       bist_busy,
    input wire logic       core_rst,
    input wire logic       chip_rst
);
    logic        used_q;
    logic [10:0] busy_cnt;
    logic [31:0] quiet_cnt;
    logic        b5_end;
    assign b5_end = cache_valid & cache_last & (cache_bank == 3'h5);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            used_q    <= 1'b0;
            busy_cnt  <= 11'h0;
            quiet_cnt <= 32'h0;
        end else begin
            used_q    <= used_q | bist_busy;
            busy_cnt  <= busy_cnt + {10'h0, bist_busy};
            // a service edge, a disable or a fire restart the quiet span; slack below covers sync delay
            quiet_cnt <= (!wdt_en || $changed(wdt_service) || core_rst) ? 32'h0 : quiet_cnt + 32'h1;
        end
    end
    // chip reset also clears the trim flag, so its core reset is no watchdog fire
    sequence wd_fire_s;
        $rose(core_rst) && !chip_rst && !$past(chip_rst) && !$past(chip_rst, 2);
    endsequence
    AST_CORE_FREE: assert property ($fell(rst_i) |-> ##[0:2] !core_rst)
        else $error("core reset held");
    AST_CRC_CAUSE: assert property ($changed(crc_err) |->
        $past(b5_end) || $past(b5_end, 2) || chip_rst || $past(chip_rst)) else $error("crc status moved");
    AST_BIST_GO: assert property (bist_start && !used_q && !bist_busy |=> bist_busy)
        else $error("self-test did not start");
    AST_BIST_ONCE: assert property ($rose(bist_busy) |-> !used_q)
        else $error("self-test ran twice");
    AST_BIST_LEN: assert property ($rose(bist_done) |-> busy_cnt >= 11'h2FE && busy_cnt <= 11'h302)
        else $error("self-test length wrong");
    AST_BIST_HOLD: assert property (bist_done && !chip_rst && !$past(chip_rst) |=>
        (bist_done && $stable(bist_fail)) || chip_rst) else $error("self-test result not held");
    AST_WDT_SPAN: assert property (wd_fire_s |-> quiet_cnt + 3 >= WDT_CYCLES && quiet_cnt <= WDT_CYCLES + 3)
        else $error("watchdog fired at wrong time");
    AST_WDT_KEEP: assert property (wd_fire_s |-> wdt_en ##1 wdt_en)
        else $error("watchdog enable lost");
    AST_CHIP_PULSE: assert property (chip_rst |-> ($past(clkmon_en) || $past(clkmon_en, 2)) ##1 !chip_rst)
        else $error("chip reset without enable");
    cover property ($rose(bist_done));
    cover property (wd_fire_s);
    cover property (chip_rst);
endmodule
`default_nettype wire

// ---- sdsup_tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp, msg) begin check_count++; if ((got) !== (exp)) begin bad_count++; $display("CHECK FAILED %0t %s", $time, msg); end end
module sdsup_tb_top
    import sdsup_pkg::*;
();
    localparam int unsigned WDT = 200;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        cyc = 1'b0;
    logic        stb = 1'b0;
    logic        we = 1'b0;
    logic [7:0]  adr = 8'h00;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rv;
    logic [8:0]  trim = 9'h1FF;
    logic        osc = 1'b0;
    logic [7:0]  crc;
    wire  [31:0] rdat;
    wire         ack;
    wire  [4:0]  lp;
    wire         dclr;
    int          osc_half = 10;
    int          oc = 0;
    int          fires = 0;
    int          crs = 0;
    int          bad_count = 0;
    int          check_count = 0;
    sdsup_if link ();
    sdsup_host sdsup_host_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .link(link));
    sdsup_device #(.WDT_CYCLES(WDT)) sdsup_device_inst (.clk_i(clk_i), .rst_i(rst_i), .osc_div_i(osc),
        .trim_word_i(trim), .bridge_supply_enable_o(lp[0]), .second_dac_enable_o(lp[1]), .front_end_enable_o(lp[2]),
        .digital_interface_clock_enable_o(lp[3]), .eeprom_clock_enable_o(lp[4]), .dac_clear_o(dclr), .link(link));
    sdsup_chk #(.WDT_CYCLES(WDT)) sdsup_chk_inst (.clk_i(clk_i), .rst_i(rst_i), .clkmon_en(link.clkmon_en),
        .wdt_en(link.wdt_en), .wdt_service(link.wdt_service), .bist_start(link.bist_start),
        .cache_valid(link.cache_valid), .cache_bank(link.cache_bank), .cache_last(link.cache_last),
        .crc_err(link.crc_err), .bist_done(link.bist_done), .bist_fail(link.bist_fail),
        .bist_busy(link.bist_busy), .core_rst(link.core_rst), .chip_rst(link.chip_rst));
    initial forever #5 clk_i = ~clk_i;
    // divided oscillator: half period in system cycles, 10 gives the nominal rate
    always @(posedge clk_i) begin
        oc <= (oc >= osc_half - 1) ? 0 : oc + 1;
        if (oc >= osc_half - 1) osc <= ~osc;
        if (dclr === 1'b1) fires <= fires + 1;
        if (link.chip_rst === 1'b1) crs <= crs + 1;
    end
    function automatic logic [7:0] crc_next(input logic [7:0] c, input logic [7:0] d);
        logic [7:0] r;
        r = c ^ d;
        for (int i = 0; i < 8; i++) r = r[7] ? {r[6:0], 1'b0} ^ CRC_POLY : {r[6:0], 1'b0};
        return r;
    endfunction
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        cyc  <= 1'b1;
        stb  <= 1'b1;
        we   <= w;
        adr  <= a;
        wdat <= d;
        do @(posedge clk_i); while (ack !== 1'b1);
        rv = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    task automatic power_up(input logic ok);
        logic [7:0] b;
        b = 8'($urandom);
        rst_i <= 1'b1;
        trim  <= {ok ? ~^b : ^b, b};
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (4) @(posedge clk_i);
        `CHK(lp, 5'h1F, "low-power enables not on")
        wb(1'b0, REG_STATUS, 32'h0);
        `CHK(rv[5:1], {4'h0, ~ok}, "status after power-up")
    endtask
    task automatic print_verdict();
        if (bad_count == 0 && check_count > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    initial begin
        logic [31:0] v;
        int n;
        void'($urandom(34));
        osc_half = 9 + int'($urandom_range(2));
        power_up(1'b1);
        wb(1'b0, REG_CTRL, 32'h0);
        `CHK(rv[3:0], 4'h1, "control reset value")
        wb(1'b0, 8'h40, 32'h0);
        `CHK(rv, 32'h0, "unmapped read")
        v = $urandom;
        wb(1'b1, REG_LOWPWR, v);
        repeat (3) @(posedge clk_i);
        `CHK(lp, v[4:0], "low-power enables")
        // second pass corrupts the stored byte; bank 0 bytes must not count
        for (int k = 0; k < 2; k++) begin
            crc = CRC_INIT;
            for (int bk = 0; bk < 6; bk++) begin
                n = (bk == 5) ? 9 : 1 + int'($urandom_range(3));
                for (int i = 0; i < n; i++) begin
                    v[7:0] = (bk == 5 && i == 8) ? crc ^ 8'(k) : 8'($urandom);
                    if (bk > 0 && !(bk == 5 && i == 8)) crc = crc_next(crc, v[7:0]);
                    wb(1'b1, REG_CACHE, {15'h0, i == n - 1, 5'h0, 3'(bk), v[7:0]});
                end
            end
            repeat (3) @(posedge clk_i);
            wb(1'b0, REG_STATUS, 32'h0);
            `CHK(rv[0], 1'(k), "crc status")
        end
        n = fires;
        wb(1'b1, REG_CTRL, 32'h3);
        repeat (5) begin
            repeat (WDT - 40 - $urandom_range(40)) @(posedge clk_i);
            wb(1'b1, REG_CTRL, 32'hB);
        end
        `CHK(fires - n, 0, "fired while serviced")
        repeat (WDT + 60) @(posedge clk_i);
        `CHK(fires - n, 1, "no single fire")
        wb(1'b0, REG_CTRL, 32'h0);
        `CHK(rv[3:0], 4'h3, "settings after fire")
        wb(1'b1, REG_CTRL, 32'h1);
        repeat (WDT * 2) @(posedge clk_i);
        `CHK(fires - n, 1, "disabled watchdog fired")
        wb(1'b1, REG_CTRL, 32'h5);
        repeat (2) @(posedge clk_i);
        wb(1'b0, REG_RAM, 32'h0);
        `CHK(rv[7:0], 8'h00, "ram open during self-test")
        n = 0;
        do begin
            wb(1'b0, REG_STATUS, 32'h0);
            n++;
        end while (rv[2] !== 1'b1 && n < 400);
        `CHK(rv[4:2], 3'h1, "self-test end flags")
        v = $urandom;
        wb(1'b1, REG_RAM, {15'h0, 1'b1, v[15:0]});
        wb(1'b0, REG_RAM, 32'h0);
        `CHK(rv[7:0], v[15:8], "ram data lost")
        wb(1'b1, REG_CTRL, 32'h5);
        repeat (2) @(posedge clk_i);
        wb(1'b0, REG_STATUS, 32'h0);
        `CHK(rv[4:2], 3'h1, "second self-test ran")
        `CHK(crs, 0, "spurious chip reset")
        for (int i = 0; i < 3; i++) begin
            wb(1'b1, REG_CTRL, {31'h0, i != 1});
            osc_half <= (i == 0) ? 14 : 7;
            n = crs;
            repeat (2000) @(posedge clk_i);
            `CHK(crs > n, i != 1, "clock watchdog reset")
            osc_half <= 10;
            repeat (2000) @(posedge clk_i);
        end
        power_up(1'b0);
        wb(1'b1, REG_CTRL, 32'h5);
        wb(1'b0, REG_STATUS, 32'h0);
        `CHK(rv[4], 1'b1, "self-test refused after power-up")
        print_verdict();
    end
    initial begin
        #400000;
        bad_count++;
        print_verdict();
    end
endmodule
`default_nettype wire
